//--- dwm_pkg.sv
// Contract
// - Timeout selection 3: warn when no Modbus frame arrives for 2 seconds.
// - Raise level-one current warning when current reaches level-one threshold.
// - Raise level-two current warning at its own threshold, independent of level one.
// - After automatic reset starts, hold retry warning until restart delay expires.
// - Retry warning possible only when restart delay or reset count is nonzero.
// - Emergency-stop warning when any terminal assigned code 14 is active.
// - Terminal one external warning: code 25 or 68, input active, handling 2.
// - Eight external-fault warnings, terminal n qualified by its own assignment.
// - Handling 2 makes external fault a warning only; operation continues.
`default_nettype none
package dwm_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned COMM_TIMEOUT_MS = 2000;
  localparam int unsigned COMM_TIMEOUT_CYC = (CLK_HZ / 1000) * COMM_TIMEOUT_MS;
  localparam int unsigned MS_CYC          = CLK_HZ / 1000;
  localparam int unsigned NUM_TERM        = 8;
  // Register indices on the plain register port.
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_CURA    = 4'h1;
  localparam logic [3:0] REG_CURB    = 4'h2;
  localparam logic [3:0] REG_RDELAY  = 4'h3;
  localparam logic [3:0] REG_RCOUNT  = 4'h4;
  localparam logic [3:0] REG_FUNC_LO = 4'h5;
  localparam logic [3:0] REG_FUNC_HI = 4'h6;
  localparam logic [3:0] REG_STATUS  = 4'h7;
  // Control register fields.
  localparam int unsigned CTRL_TOSEL_LSB = 0;
  localparam int unsigned CTRL_EFSEL_LSB = 4;
  localparam logic [3:0] TOSEL_WARN  = 4'h3;
  localparam logic [3:0] EFSEL_WARN  = 4'h2;
  // Terminal function codes.
  localparam logic [7:0] FN_ESTOP    = 8'h0e;
  localparam logic [7:0] FN_EXTF_A   = 8'h19;
  localparam logic [7:0] FN_EXTF_B   = 8'h44;
endpackage : dwm_pkg
`default_nettype wire

//--- dwm_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Millisecond down-counter for the restart delay; busy while time remains.
module dwm_delay_timer
  import dwm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] delay_ms_i,
  output logic             busy_o
);
  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] ms;
    logic        busy;
  } dwm_tmr_t;
  dwm_tmr_t s_q, s_d;

  // Prescaler gives a one-cycle millisecond tick while counting.
  always_comb begin
    s_d = s_q;
    if (start_i) begin
      s_d.pre  = '0;
      s_d.ms   = delay_ms_i;
      s_d.busy = (delay_ms_i != 16'h0000);
    end else if (s_q.busy) begin
      if (s_q.pre == MS_CYCLES - 1) begin
        s_d.pre = '0;
        s_d.ms  = s_q.ms - 16'h0001;
        if (s_q.ms == 16'h0001) begin
          s_d.busy = 1'b0;
        end
      end else begin
        s_d.pre = s_q.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
endmodule // dwm_delay_timer
`default_nettype wire

//--- dwm_warning_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Warning monitor for the drive supervisor; external faults trip unless handling is 2.
module dwm_warning_monitor
  import dwm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = COMM_TIMEOUT_CYC,
  parameter int unsigned MS_CYCLES      = MS_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        frame_rx_i,
  input  wire logic [15:0] current_i,
  input  wire logic        auto_reset_start_i,
  input  wire logic [7:0]  term_in_i,
  output logic             comm_loss_warning_o,
  output logic             current_level_one_warning_o,
  output logic             current_level_two_warning_o,
  output logic             retry_warning_o,
  output logic             emergency_stop_warning_o,
  output logic [7:0]       ext_fault_warn_o,
  output logic             ext_fault_trip_o
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] rdelay;
    logic [15:0] rcount;
    logic [63:0] func;
    logic [31:0] idle;
    logic        comm;
    logic        lvl_one;
    logic        lvl_two;
    logic        estop;
    logic [7:0]  ef;
    logic        trip;
    logic [31:0] rdata;
  } dwm_state_t;
  dwm_state_t s_q, s_d;

  logic retry_busy;
  logic retry_start;

  // Function code of one terminal, used for every terminal check.
  function automatic logic [7:0] term_fn(input logic [63:0] f, input int unsigned n);
    term_fn = f[8*n +: 8];
  endfunction

  // Retry is only armed when one of the two settings is nonzero.
  assign retry_start = auto_reset_start_i &&
                       ((s_q.rdelay != 16'h0000) || (s_q.rcount != 16'h0000));

  dwm_delay_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_delay (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (retry_start),
    .delay_ms_i (s_q.rdelay),
    .busy_o     (retry_busy)
  );

  // Register writes, warning evaluation and registered read data.
  always_comb begin
    logic       estop_hit;
    logic [3:0] tosel;
    logic [3:0] efsel;
    estop_hit = 1'b0;
    s_d   = s_q;
    tosel = s_q.ctrl[CTRL_TOSEL_LSB +: 4];
    efsel = s_q.ctrl[CTRL_EFSEL_LSB +: 4];
    if (reg_we_i) begin
      unique case (reg_addr_i)
        REG_CTRL:    s_d.ctrl = reg_wdata_i[7:0];
        REG_CURA:    s_d.cur_a = reg_wdata_i[15:0];
        REG_CURB:    s_d.cur_b = reg_wdata_i[15:0];
        REG_RDELAY:  s_d.rdelay = reg_wdata_i[15:0];
        REG_RCOUNT:  s_d.rcount = reg_wdata_i[15:0];
        REG_FUNC_LO: s_d.func[31:0] = reg_wdata_i;
        REG_FUNC_HI: s_d.func[63:32] = reg_wdata_i;
        default:     s_d.ctrl = s_q.ctrl;
      endcase
    end
    // Idle counter restarts on every frame; saturates to avoid wrapping.
    if (frame_rx_i) begin
      s_d.idle = '0;
    end else if (s_q.idle < TIMEOUT_CYCLES) begin
      s_d.idle = s_q.idle + 32'h1;
    end
    s_d.comm = (tosel == TOSEL_WARN) && (s_q.idle >= TIMEOUT_CYCLES);
    // Each level compares on its own so both may be up together.
    s_d.lvl_one = (current_i >= s_q.cur_a);
    s_d.lvl_two = (current_i >= s_q.cur_b);
    for (int unsigned n = 0; n < NUM_TERM; n++) begin
      if (term_in_i[n] && term_fn(s_q.func, n) == FN_ESTOP) begin
        estop_hit = 1'b1;
      end
      s_d.ef[n] = term_in_i[n] && (efsel == EFSEL_WARN) &&
                  (term_fn(s_q.func, n) == FN_EXTF_A ||
                   term_fn(s_q.func, n) == FN_EXTF_B);
    end
    // Emergency stop follows its input; the outside drops run and input to clear it.
    s_d.estop = estop_hit;
    // Other handling selections trip; selection 2 keeps running.
    s_d.trip = 1'b0;
    for (int unsigned n = 0; n < NUM_TERM; n++) begin
      if (term_in_i[n] && efsel != EFSEL_WARN &&
          (term_fn(s_q.func, n) == FN_EXTF_A || term_fn(s_q.func, n) == FN_EXTF_B)) begin
        s_d.trip = 1'b1;
      end
    end
    s_d.rdata = 32'h0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_CTRL:    s_d.rdata = {24'h0, s_q.ctrl};
        REG_CURA:    s_d.rdata = {16'h0, s_q.cur_a};
        REG_CURB:    s_d.rdata = {16'h0, s_q.cur_b};
        REG_RDELAY:  s_d.rdata = {16'h0, s_q.rdelay};
        REG_RCOUNT:  s_d.rdata = {16'h0, s_q.rcount};
        REG_FUNC_LO: s_d.rdata = s_q.func[31:0];
        REG_FUNC_HI: s_d.rdata = s_q.func[63:32];
        REG_STATUS:  s_d.rdata = {16'h0, s_q.ef, s_q.trip, s_q.estop, retry_busy,
                                  s_q.lvl_two, s_q.lvl_one, s_q.comm, 2'b00};
        default:     s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o                 = s_q.rdata;
  assign comm_loss_warning_o         = s_q.comm;
  assign current_level_one_warning_o = s_q.lvl_one;
  assign current_level_two_warning_o = s_q.lvl_two;
  assign retry_warning_o             = retry_busy;
  assign emergency_stop_warning_o    = s_q.estop;
  assign ext_fault_warn_o            = s_q.ef;
  assign ext_fault_trip_o            = s_q.trip;
endmodule // dwm_warning_monitor
`default_nettype wire

//--- dwm_warning_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checker; idle_q counts cycles since the last received frame.
module dwm_chk #(parameter int unsigned TIMEOUT_CYCLES = 50) (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        frame_rx_i,
  input wire logic        auto_reset_start_i,
  input wire logic [7:0]  term_in_i,
  input wire logic        comm_loss_warning_o,
  input wire logic        retry_warning_o,
  input wire logic        emergency_stop_warning_o,
  input wire logic [7:0]  ext_fault_warn_o,
  input wire logic        ext_fault_trip_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] idle_q;
  // Saturates so a long silence cannot wrap back below the timeout.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || frame_rx_i) idle_q <= 32'h0;
    else if (idle_q != 32'hffffffff) idle_q <= idle_q + 32'h1;
  end
  a_comm_rise: assert property ($rose(comm_loss_warning_o) |-> idle_q > TIMEOUT_CYCLES)
    else $error("comm warning rose too early");
  a_comm_clear: assert property (frame_rx_i |-> ##3 !comm_loss_warning_o)
    else $error("comm warning kept after a frame");
  a_retry_hold: assert property ($rose(retry_warning_o) |-> $past(auto_reset_start_i) ##0 retry_warning_o[*4])
    else $error("retry warning without start or too short");
  a_estop_cause: assert property (emergency_stop_warning_o |-> $past(term_in_i) != 8'h00)
    else $error("estop warning with no input");
  a_extf_cause: assert property ((ext_fault_warn_o & ~$past(term_in_i)) == 8'h00)
    else $error("ext fault warning on idle terminal");
  a_warn_no_trip: assert property (ext_fault_warn_o != 8'h00 |-> !ext_fault_trip_o)
    else $error("trip beside ext fault warning");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property ($past(reg_re_i) && $past(reg_addr_i) > 4'h7 |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  c_retry: cover property ($rose(retry_warning_o));
  c_estop: cover property ($rose(emergency_stop_warning_o));
  c_comm: cover property ($rose(comm_loss_warning_o));
endmodule // dwm_chk
`default_nettype wire

//--- dwm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Modbus host: one frame pulse every eight cycles while enabled.
module dwm_host_model (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      frame_o
);
  logic [2:0] gap_q;
  // Dropping en_i models a broken wire, which is how the timeout is provoked.
  always_ff @(posedge core_clk_i) begin
    gap_q   <= rst_i ? 3'h0 : gap_q + 3'h1;
    frame_o <= en_i && !rst_i && gap_q == 3'h7;
  end
endmodule // dwm_host_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import dwm_pkg::*;;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, re = 1'b0, st = 1'b0, host_en = 1'b1;
  logic        frame, comm, lvl_one, lvl_two, retry, estop, trip;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] current_i = 16'h0;
  logic [7:0]  term_in_i = 8'h0, extf;
  int          mismatches = 0, compares = 0;
  // Short counts keep the timeout and the restart delay within a quick run.
  dwm_warning_monitor #(.TIMEOUT_CYCLES(50), .MS_CYCLES(4)) DUT (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .frame_rx_i(frame), .current_i(current_i), .auto_reset_start_i(st),
    .term_in_i(term_in_i), .comm_loss_warning_o(comm), .current_level_one_warning_o(lvl_one),
    .current_level_two_warning_o(lvl_two), .retry_warning_o(retry),
    .emergency_stop_warning_o(estop), .ext_fault_warn_o(extf), .ext_fault_trip_o(trip));
  dwm_host_model u_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .en_i(host_en), .frame_o(frame));
  always #5 core_clk_i = ~core_clk_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Settle after the edges so registered outputs are compared once stable.
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge core_clk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr <= a;
    re <= 1'b1;
    // Drop the strobe on the edge that takes it; read data stand in the next cycle only.
    @(posedge core_clk_i);
    re <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic kick();
    @(posedge core_clk_i);
    st <= 1'b1;
    @(posedge core_clk_i);
    st <= 1'b0;
    wt(1);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Zero thresholds count as reached, so both current levels are up after reset.
    rd(REG_STATUS, 32'h18);
    wr(REG_CTRL, 32'h22);
    host_en <= 1'b0;
    wt(60); chk("comm_sel2", 0, comm);
    wr(REG_CTRL, 32'h23);
    wt(60); chk("comm_lost", 1, comm);
    @(posedge core_clk_i);
    host_en <= 1'b1;
    wt(12); chk("comm_back", 0, comm);
    $display("comm test done");
    wr(REG_CURA, 32'h100); wr(REG_CURB, 32'h200);
    current_i <= 16'h0100;
    wt(2); chk("level_one", 1, lvl_one); chk("level_two", 0, lvl_two);
    @(posedge core_clk_i);
    current_i <= 16'h0200;
    wt(2); chk("level_two", 1, lvl_two);
    wr(REG_FUNC_LO, 32'h000e4419); wr(REG_FUNC_HI, 32'h44194419);
    term_in_i <= 8'hff;
    wt(2); chk("extf", 32'hf3, {24'h0, extf}); chk("estop", 1, estop);
    rd(REG_STATUS, 32'hf358);
    @(posedge core_clk_i);
    term_in_i <= 8'h08;
    wt(2); chk("extf_unassigned", 0, {24'h0, extf}); chk("estop_off", 0, estop);
    wr(REG_CTRL, 32'h03);
    term_in_i <= 8'h01;
    wt(2); chk("trip", 1, trip); chk("extf_sel0", 0, {24'h0, extf});
    @(posedge core_clk_i);
    term_in_i <= 8'h00;
    wt(2); chk("trip_off", 0, trip);
    $display("terminal test done");
    wr(REG_RDELAY, 32'h2);
    kick(); chk("retry_on", 1, retry);
    // Two milliseconds of four cycles each: up for eight cycles, gone on the ninth.
    wt(6); chk("retry_hold", 1, retry);
    wt(1); chk("retry_off", 0, retry);
    wr(REG_RDELAY, 32'h0); wr(REG_RCOUNT, 32'h1);
    kick(); chk("retry_zero", 0, retry);
    $display("retry test done");
    rd(4'hf, 32'h0);
    wr(REG_STATUS, 32'hffff);
    rd(REG_STATUS, 32'h18);
    $display("register test done");
    tally_and_finish();
  end
  initial begin
    #20us;
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
bind dwm_warning_monitor dwm_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .core_clk_i               (core_clk_i),
  .rst_i                    (rst_i),
  .reg_addr_i               (reg_addr_i),
  .reg_re_i                 (reg_re_i),
  .reg_rdata_o              (reg_rdata_o),
  .frame_rx_i               (frame_rx_i),
  .auto_reset_start_i       (auto_reset_start_i),
  .term_in_i                (term_in_i),
  .comm_loss_warning_o      (comm_loss_warning_o),
  .retry_warning_o          (retry_warning_o),
  .emergency_stop_warning_o (emergency_stop_warning_o),
  .ext_fault_warn_o         (ext_fault_warn_o),
  .ext_fault_trip_o         (ext_fault_trip_o)
);
`default_nettype wire
